// ===== iosm_cfg.svh
`ifndef IOSM_CFG_SVH
`define IOSM_CFG_SVH

// Matrix dimensions
`define IOSM_NUM_SRC      25
`define IOSM_NUM_DST      18
`define IOSM_NUM_PWM      4
`define IOSM_NUM_SEQ      16
`define IOSM_SYNC_W       9

// Tick of every programmable duration is one system clock
`define IOSM_CLK_PERIOD_NS 100
`define IOSM_TICK_NS       `IOSM_CLK_PERIOD_NS
`define IOSM_FULL_PERCENT  8'h64

// Register byte offsets
`define IOSM_OFS_SEL_BASE  12'h000
`define IOSM_OFS_INV       12'h048
`define IOSM_OFS_FORCE     12'h04c
`define IOSM_OFS_CTRL      12'h050
`define IOSM_OFS_SRC_STAT  12'h054
`define IOSM_OFS_DST_STAT  12'h058
`define IOSM_OFS_PER_BASE  12'h100
`define IOSM_OFS_DUTY_BASE 12'h140
`define IOSM_OFS_DUTY_END  12'h180

// Field positions
`define IOSM_CTRL_DEBUG    0
`define IOSM_DUTY_FLD_W    8

// Reset values
`define IOSM_RST_SEL       25'h0000000
`define IOSM_RST_MASK      18'h00000
`define IOSM_RST_CTRL      1'h0
`define IOSM_RST_PERIOD    24'h000000
`define IOSM_RST_DUTY      32'h00000000

`endif

// ===== iosm_pkg.sv
package iosm_pkg;

  typedef logic [24:0] iosm_src_t;
  typedef logic [17:0] iosm_dst_t;
  typedef logic [23:0] iosm_period_t;
  typedef logic [7:0]  iosm_duty_t;
  typedef logic [3:0]  iosm_seq_t;

  typedef enum logic [0:0] {
    IOSM_PWM_IDLE = 1'b0,
    IOSM_PWM_RUN  = 1'b1
  } iosm_pwm_state_e;

endpackage : iosm_pkg

// ===== iosm_sync.sv
`timescale 1ns/1ps
module iosm_sync
  import iosm_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : iosm_sync

// ===== iosm_pwm.sv
`timescale 1ns/1ps
`include "iosm_cfg.svh"
module iosm_pwm
  import iosm_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire iosm_period_t period_i,
  input  wire iosm_duty_t   duty_i,
  output logic              pwm_o
);

  iosm_pwm_state_e state_q, state_d;
  iosm_period_t    cnt_q, cnt_d;
  iosm_period_t    per_q, per_d;
  iosm_period_t    on_q, on_d;
  logic            out_q, out_d;

  // Percent above full scale is clamped
  wire iosm_duty_t duty_c_w = (duty_i > `IOSM_FULL_PERCENT) ?
                              `IOSM_FULL_PERCENT : duty_i;
  wire [31:0] prod_w = 32'(period_i) * 32'(duty_c_w);
  wire iosm_period_t on_w = 24'(prod_w / 32'd100);
  wire last_w = (cnt_q == per_q - 24'h000001);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    per_d   = per_q;
    on_d    = on_q;
    case (state_q)
      IOSM_PWM_IDLE:
      begin
        cnt_d = '0;
        if (period_i != '0)
        begin
          per_d   = period_i;
          on_d    = on_w;
          state_d = IOSM_PWM_RUN;
        end
      end
      IOSM_PWM_RUN:
      begin
        cnt_d = cnt_q + 24'h000001;
        // New settings only at a period boundary, never mid-pulse
        if (last_w)
        begin
          cnt_d = '0;
          per_d = period_i;
          on_d  = on_w;
          if (period_i == '0)
            state_d = IOSM_PWM_IDLE;
        end
      end
      default: state_d = IOSM_PWM_IDLE;
    endcase
    out_d = (state_d == IOSM_PWM_RUN) && (cnt_d < on_d);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= IOSM_PWM_IDLE;
      cnt_q   <= '0;
      per_q   <= '0;
      on_q    <= '0;
      out_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      per_q   <= per_d;
      on_q    <= on_d;
      out_q   <= out_d;
    end
  end

  assign pwm_o = out_q;

endmodule : iosm_pwm

// ===== iosm_top.sv
// What this block does
// - Sources 0..24; inputs 0..3 are triggers
// - Pulse-loop outputs on sources 6,7,20,21
// - Sequencer PWM and pulses on fixed sources
// - Debounce 16, prescale 17, logic 19
// - Destinations 0..17; txd only without debug
// - Module inputs on destinations 5..17
// - Inversion passes the complement
// - Force-high drives the line high
// - Force plus inversion drives low
// - PWM period equals period ticks
// - Per-entry percent duty per channel
// - Durations counted in system clock ticks
`timescale 1ns/1ps
`include "iosm_cfg.svh"
module iosm_top
  import iosm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Pins, asynchronous
  input  wire logic [3:0]  trig_in_i,
  input  wire logic        serial_rx_i,
  input  wire logic        lens_rx_i,
  input  wire logic        expose_i,
  input  wire logic        readout_i,
  input  wire logic        trig_feedback_i,
  // Internal modules, same clock
  input  wire logic        first_serial_tx_source_i,
  input  wire logic        second_serial_tx_source_i,
  input  wire logic [3:0]  pulse_loop_i,
  input  wire logic        seq_pulse_a_i,
  input  wire logic        seq_pulse_b_i,
  input  wire logic        seq_active_i,
  input  wire iosm_seq_t   interval_index_i,
  input  wire logic        debounce_i,
  input  wire logic        prescale_i,
  input  wire logic        logic_result_i,
  // Destinations
  output logic      [3:0]  od_o,
  output logic      [3:0]  od_oe_o,
  output logic             serial_tx_o,
  output logic             serial_tx_oe_o,
  output logic             first_serial_rx_dest_o,
  output logic             camera_trigger_o,
  output logic             interval_engine_start_o,
  output logic             debounce_in_o,
  output logic             prescale_in_o,
  output logic             logic_in_a_o,
  output logic             logic_in_b_o,
  output logic             lens_tx_o,
  output logic      [3:0]  pulse_loop_trig_o,
  output logic             second_serial_rx_dest_o,
  output logic      [3:0]  seq_pwm_o
);

  // Configuration storage
  iosm_src_t    sel_q [`IOSM_NUM_DST];
  iosm_dst_t    inv_q;
  iosm_dst_t    force_q;
  logic         debug_q;
  iosm_period_t pwm_period_ticks_q [`IOSM_NUM_SEQ];
  // Duty row: one percent byte per channel, channel A lowest
  logic [31:0]  pwm_duty_percent_q [`IOSM_NUM_SEQ];

  // Bus handshake
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_w;

  // Outputs
  iosm_dst_t   dst_q;
  logic [3:0]  od_oe_q;
  logic        txd_oe_q;

  // Synchronised pins, packed in a fixed order
  logic [`IOSM_SYNC_W-1:0] pin_raw_w;
  logic [`IOSM_SYNC_W-1:0] pin_s;

  assign pin_raw_w[3:0] = trig_in_i;
  assign pin_raw_w[4]   = serial_rx_i;
  assign pin_raw_w[5]   = lens_rx_i;
  assign pin_raw_w[6]   = expose_i;
  assign pin_raw_w[7]   = readout_i;
  assign pin_raw_w[8]   = trig_feedback_i;

  // Bits are synced apart; two pins may land one clock apart
  iosm_sync #(
    .W (`IOSM_SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (pin_raw_w),
    .sync_o  (pin_s)
  );

  logic [3:0] pwm_w;

  // Source vector
  iosm_src_t src_w;
  assign src_w[3:0] = pin_s[3:0];
  assign src_w[4]   = pin_s[4];

  // Module outputs share this clock and skip the sync
  assign src_w[5]   = first_serial_tx_source_i;
  assign src_w[6]   = pulse_loop_i[0];
  assign src_w[7]   = pulse_loop_i[1];
  assign src_w[8]   = pwm_w[0];
  assign src_w[9]   = pwm_w[1];

  // Status pins, synchronised
  assign src_w[10]  = pin_s[6];
  assign src_w[11]  = pin_s[7];

  // Sequencer pulses, flags and the second PWM pair
  assign src_w[12]  = seq_pulse_a_i;
  assign src_w[13]  = pwm_w[2];
  assign src_w[14]  = pwm_w[3];
  assign src_w[15]  = seq_active_i;

  // Filter, prescale, second sequencer pulse and logic results
  assign src_w[16]  = debounce_i;
  assign src_w[17]  = prescale_i;
  assign src_w[18]  = seq_pulse_b_i;
  assign src_w[19]  = logic_result_i;

  // Upper numbers mix module outputs and synced pins
  assign src_w[20]  = pulse_loop_i[2];
  assign src_w[21]  = pulse_loop_i[3];
  assign src_w[22]  = pin_s[5];
  assign src_w[23]  = pin_s[8];
  assign src_w[24]  = second_serial_tx_source_i;

  // Routing, one stage per destination
  iosm_dst_t dst_d;
  genvar g;
  generate
    for (g = 0; g < `IOSM_NUM_DST; g++)
    begin : g_route
      // Several set bits are ORed rather than refused
      wire sel_w   = |(sel_q[g] & src_w);
      wire level_w = force_q[g] ? 1'b1 : sel_w;
      assign dst_d[g] = level_w ^ inv_q[g];
    end
  endgenerate

  // Active interval picks one period row for all four channels
  wire iosm_period_t period_w = pwm_period_ticks_q[interval_index_i];

  // Per-channel PWM, settings picked by the active interval
  generate
    for (g = 0; g < `IOSM_NUM_PWM; g++)
    begin : g_pwm
      wire iosm_duty_t duty_w =
        pwm_duty_percent_q[interval_index_i][g*8 +: 8];
      iosm_pwm u_pwm (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .period_i (period_w),
        .duty_i   (duty_w),
        .pwm_o    (pwm_w[g])
      );
    end
  endgenerate

  // Bus decode
  wire        req_w   = avs_read_i | avs_write_i;
  wire        wr_w    = avs_write_i & ~wait_q;
  wire [11:0] a_w     = avs_address_i;
  wire        sel_a_w = (a_w < `IOSM_OFS_INV) && (a_w[1:0] == 2'h0);
  wire        per_a_w = (a_w >= `IOSM_OFS_PER_BASE) &&
                        (a_w < `IOSM_OFS_DUTY_BASE) &&
                        (a_w[1:0] == 2'h0);
  wire        dut_a_w = (a_w >= `IOSM_OFS_DUTY_BASE) &&
                        (a_w < `IOSM_OFS_DUTY_END) &&
                        (a_w[1:0] == 2'h0);
  wire [4:0]  sel_i_w = a_w[6:2];
  wire [3:0]  tbl_i_w = a_w[5:2];
  wire        inv_a_w = (a_w == `IOSM_OFS_INV);
  wire        frc_a_w = (a_w == `IOSM_OFS_FORCE);
  wire        ctl_a_w = (a_w == `IOSM_OFS_CTRL);

  always_comb
  begin
    rdata_w = 32'h00000000;
    if (sel_a_w)
      rdata_w = {7'h00, sel_q[sel_i_w]};
    else if (a_w == `IOSM_OFS_INV)
      rdata_w = {14'h0000, inv_q};
    else if (a_w == `IOSM_OFS_FORCE)
      rdata_w = {14'h0000, force_q};
    else if (a_w == `IOSM_OFS_CTRL)
      rdata_w = {31'h00000000, debug_q};
    else if (a_w == `IOSM_OFS_SRC_STAT)
      rdata_w = {7'h00, src_w};
    else if (a_w == `IOSM_OFS_DST_STAT)
      rdata_w = {14'h0000, dst_q};
    else if (per_a_w)
      rdata_w = {8'h00, pwm_period_ticks_q[tbl_i_w]};
    else if (dut_a_w)
      rdata_w = pwm_duty_percent_q[tbl_i_w];
    else
      rdata_w = 32'h00000000;
  end

  // One wait cycle, then a single ready cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      wait_q <= 1'b1;
    else
      wait_q <= ~(req_w & wait_q);
  end

  // Captured on the taking edge so the answer stands while ready
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_q <= 32'h00000000;
    else if (avs_read_i & wait_q)
      rdata_q <= rdata_w;
  end

  // Register writes; a table row holds one interval's settings
  generate
    for (g = 0; g < `IOSM_NUM_DST; g++)
    begin : g_sel_reg
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
          sel_q[g] <= `IOSM_RST_SEL;
        else if (wr_w && sel_a_w && sel_i_w == 5'(g))
          sel_q[g] <= avs_writedata_i[24:0];
      end
    end
    for (g = 0; g < `IOSM_NUM_SEQ; g++)
    begin : g_tbl_reg
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
        begin
          pwm_period_ticks_q[g] <= `IOSM_RST_PERIOD;
          pwm_duty_percent_q[g] <= `IOSM_RST_DUTY;
        end
        else if (wr_w && tbl_i_w == 4'(g))
        begin
          if (per_a_w)
            pwm_period_ticks_q[g] <= avs_writedata_i[23:0];
          if (dut_a_w)
            pwm_duty_percent_q[g] <= avs_writedata_i;
        end
      end
    end
  endgenerate

  // Inversion mask, one bit per destination
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      inv_q <= `IOSM_RST_MASK;
    else if (wr_w && inv_a_w)
      inv_q <= avs_writedata_i[17:0];
  end

  // Force acts before inversion, so both together give low
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      force_q <= `IOSM_RST_MASK;
    else if (wr_w && frc_a_w)
      force_q <= avs_writedata_i[17:0];
  end

  // Debug releases only the transmit driver; routing runs on
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      debug_q <= `IOSM_RST_CTRL;
    else if (wr_w && ctl_a_w)
      debug_q <= avs_writedata_i[`IOSM_CTRL_DEBUG];
  end

  // Output stage; costs one cycle of latency so every pin is a flop
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      dst_q <= '0;
    else
      dst_q <= dst_d;
  end

  // Open-drain enables come off the routed value so they stay in step with dst_q; the transmit enable comes off debug_q
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      od_oe_q  <= 4'h0;
      txd_oe_q <= 1'b0;
    end
    else
    begin
      od_oe_q  <= ~dst_d[3:0];
      txd_oe_q <= ~debug_q;
    end
  end

  assign avs_readdata_o          = rdata_q;
  assign avs_waitrequest_o       = wait_q;
  // Open drain only ever pulls low
  assign od_o                    = 4'h0;
  assign od_oe_o                 = od_oe_q;
  // Transmit value always routed; only the enable obeys debug
  assign serial_tx_o             = dst_q[4];
  assign serial_tx_oe_o          = txd_oe_q;
  // Module inputs and internal lines
  assign first_serial_rx_dest_o  = dst_q[5];
  assign camera_trigger_o        = dst_q[6];
  assign interval_engine_start_o = dst_q[7];
  assign debounce_in_o           = dst_q[8];
  assign prescale_in_o           = dst_q[9];
  assign logic_in_a_o            = dst_q[10];
  assign logic_in_b_o            = dst_q[11];
  assign lens_tx_o               = dst_q[12];
  assign pulse_loop_trig_o       = dst_q[16:13];
  assign second_serial_rx_dest_o = dst_q[17];
  // PWM channels leave straight from their own flops
  assign seq_pwm_o               = pwm_w;

endmodule : iosm_top

// ===== iosm_top_properties.sv
`timescale 1ns/1ps
module iosm_top_properties
  import iosm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic [3:0]  od_o,
  input  wire logic [3:0]  od_oe_o,
  input  wire logic        serial_tx_oe_o,
  input  wire logic [3:0]  seq_pwm_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  wire req = avs_read_i || avs_write_i;

  a_od_zero: assert property (od_o == 4'h0)
    else $error("open-drain value not low");
  a_ack_next: assert property (
    req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not acknowledged after one wait cycle");
  a_ack_once: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("acknowledge longer than one cycle");
  a_no_spurious: assert property (!req |=> avs_waitrequest_o)
    else $error("acknowledge without request");
  a_rdata_hold: assert property (
    !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  // Checked while reset is low, so no disable here
  a_rst_outs: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !rst_n_i |=> avs_waitrequest_o && od_oe_o == 4'h0 && !serial_tx_oe_o)
    else $error("outputs not at reset level");
  a_oe_release: assert property (
    $rose(rst_n_i) |=> od_oe_o == 4'hf && serial_tx_oe_o)
    else $error("unrouted open-drain lines not pulled low");
  a_pwm_quiet: assert property (
    $rose(rst_n_i) |-> (seq_pwm_o == 4'h0) [*3])
    else $error("pwm active with zero period");

  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_write: cover property (avs_write_i && !avs_waitrequest_o);
  c_pwm: cover property ($rose(seq_pwm_o[0]));
endmodule : iosm_top_properties

bind iosm_top iosm_top_properties iosm_top_properties_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .od_o(od_o), .od_oe_o(od_oe_o),
  .serial_tx_oe_o(serial_tx_oe_o), .seq_pwm_o(seq_pwm_o));

// ===== iosm_far_model.sv
`timescale 1ns/1ps
module iosm_far_model
(
  input  wire logic [24:0] src_i,
  input  wire logic [3:0]  od_oe_i,
  input  wire logic        tx_i,
  input  wire logic        tx_oe_i,
  output logic      [3:0]  trig_o,
  output logic      [4:0]  pins_o,
  output logic      [3:0]  od_line_o,
  output logic             tx_line_o
);
  // Cable side; pull-ups hold every released line high
  assign trig_o    = src_i[3:0];
  assign pins_o    = {src_i[23:22], src_i[11:10], src_i[4]};
  assign od_line_o = ~od_oe_i;
  assign tx_line_o = tx_oe_i ? tx_i : 1'b1;
endmodule : iosm_far_model

// ===== iosm_top_test.sv
`timescale 1ns/1ps
`include "iosm_cfg.svh"
module iosm_top_test
  import iosm_pkg::*;
;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, smp = 0;
  logic [11:0] adr = '0;
  logic [31:0] wdat = '0, obs = '0, rdat, ri, pp;
  logic [24:0] src = '0;
  iosm_seq_t   idx = '0;
  logic        wt, txo, txoe, txl;
  logic [3:0]  trig, odl, pwm, od, odoe;
  logic [4:0]  pins;
  logic [17:5] dh;
  logic [17:0] dv, iv, fo;
  logic [31:0] hi [4];
  logic [31:0] q [$];
  int          error_cnt = 0, num_checks = 0, d, i;

  assign dv = {dh, txl, odl};
  always #50 clk = ~clk;

  iosm_far_model iosm_far_model_i (.src_i(src), .od_oe_i(odoe), .tx_i(txo),
    .tx_oe_i(txoe), .trig_o(trig), .pins_o(pins), .od_line_o(odl),
    .tx_line_o(txl));

  iosm_top iosm_top_i (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .trig_in_i(trig),
    .serial_rx_i(pins[0]), .lens_rx_i(pins[3]), .expose_i(pins[1]),
    .readout_i(pins[2]), .trig_feedback_i(pins[4]),
    .first_serial_tx_source_i(src[5]), .second_serial_tx_source_i(src[24]),
    .pulse_loop_i({src[21:20], src[7:6]}), .seq_pulse_a_i(src[12]),
    .seq_pulse_b_i(src[18]), .seq_active_i(src[15]),
    .interval_index_i(idx), .debounce_i(src[16]), .prescale_i(src[17]),
    .logic_result_i(src[19]), .od_o(od), .od_oe_o(odoe), .serial_tx_o(txo),
    .serial_tx_oe_o(txoe), .first_serial_rx_dest_o(dh[5]),
    .camera_trigger_o(dh[6]), .interval_engine_start_o(dh[7]),
    .debounce_in_o(dh[8]), .prescale_in_o(dh[9]), .logic_in_a_o(dh[10]),
    .logic_in_b_o(dh[11]), .lens_tx_o(dh[12]),
    .pulse_loop_trig_o(dh[16:13]), .second_serial_rx_dest_o(dh[17]),
    .seq_pwm_o(pwm));

  task automatic bus(input logic r, input logic [11:0] a,
                     input logic [31:0] v);
    @(posedge clk);
    adr  <= a;
    wdat <= v;
    rd   <= r;
    wr   <= !r;
    do @(posedge clk); while (wt);
    rd <= 0;
    wr <= 0;
  endtask : bus

  task automatic rdx(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1, a, '0);
  endtask : rdx

  // Port samples go through the same queue as read data
  task automatic look(input logic [31:0] v, input logic [31:0] e);
    q.push_back(e);
    obs <= v;
    smp <= 1;
    @(posedge clk);
    smp <= 0;
    @(posedge clk);
  endtask : look

  task automatic chk(input logic [31:0] g);
    logic [31:0] e;
    e = q.pop_front();
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  always @(posedge clk)
  begin
    if (rd && !wt) chk(rdat);
    if (smp) chk(obs);
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    void'($urandom(7874));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    rdx(`IOSM_OFS_INV, '0);
    rdx(`IOSM_OFS_CTRL, '0);
    bus(0, 12'h05c, $urandom);
    rdx(12'h05c, '0);
    d = 0;
    for (int n = 0; n < 25; n++)
    begin
      if (n inside {8, 9, 13, 14}) continue;
      bus(0, `IOSM_OFS_SEL_BASE + 12'(4 * d), 32'(1) << n);
      repeat (2)
      begin
        src <= 25'($urandom);
        repeat (4) @(posedge clk);
        look(32'(dv[d]), 32'(src[n]));
      end
      d = (d + 1) % 18;
    end
    for (int k = 0; k < 18; k++)
      bus(0, `IOSM_OFS_SEL_BASE + 12'(4 * k), '0);
    repeat (3)
    begin
      iv = 18'($urandom);
      fo = 18'($urandom);
      bus(0, `IOSM_OFS_INV, 32'(iv));
      bus(0, `IOSM_OFS_FORCE, 32'(fo));
      repeat (2) @(posedge clk);
      look(32'(dv), 32'(fo ^ iv));
      rdx(`IOSM_OFS_DST_STAT, 32'(fo ^ iv));
    end
    for (int k = 1; k >= 0; k--)
    begin
      bus(0, `IOSM_OFS_CTRL, 32'(k));
      repeat (2) @(posedge clk);
      look(32'(txoe), 32'(k == 0));
    end
    i = $urandom_range(15);
    idx <= 4'(i);
    bus(0, `IOSM_OFS_PER_BASE + 12'(4 * i), 32'd10);
    bus(0, `IOSM_OFS_DUTY_BASE + 12'(4 * i), 32'hc8643219);
    repeat (30) @(posedge clk);
    hi = '{default: '0};
    ri = '0;
    pp = 32'(pwm[0]);
    repeat (40)
    begin
      @(posedge clk);
      for (int c = 0; c < 4; c++) hi[c] += 32'(pwm[c]);
      ri += 32'(pwm[0] & ~pp[0]);
      pp = 32'(pwm[0]);
    end
    look(hi[0], 32'd8);
    look(hi[1], 32'd20);
    look(hi[2], 32'd40);
    look(hi[3], 32'd40);
    look(ri, 32'd4);
    // Full-duty channels C and D routed out, inverted where masked
    bus(0, `IOSM_OFS_SEL_BASE + 12'h018, 32'(1) << 13);
    bus(0, `IOSM_OFS_SEL_BASE + 12'h01c, 32'(1) << 14);
    repeat (2) @(posedge clk);
    look(32'(dh[7:6]), {30'h00000000, ~iv[7:6]});
    end_sim();
  end
endmodule : iosm_top_test
